/* pdc_dma_channel.sv */
// Peripheral DMA channel with request arbitration and AXI4-Lite registers
`timescale 1ns/1ps
`include "pdc_cfg.svh"
module pdc_dma_channel
  import pdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        trigEvent,
  input  wire logic        dirToStore,
  input  wire logic [7:0]  periphRdData,
  output logic             periphRdStb,
  output logic [7:0]       periphWrData,
  output logic             periphWrStb,
  input  wire pdc_prio_t   currentPriority,
  input  wire logic        irqReq,
  input  wire pdc_prio_t   irqPrio,
  input  wire logic        topIsrActive,
  input  wire logic        instrDone,
  output logic             dmaAck,
  output logic             irqAck,
  output logic             cpuHold,
  output logic             blockEndIrq,
  output pdc_prio_t        blockEndPrio,
  input  wire logic [7:0]  interruptSegReg,
  input  wire logic [7:0]  transferSegReg,
  output logic             memReq,
  output logic             memWe,
  output logic [23:0]      memAddr,
  output logic [7:0]       memWrData,
  input  wire logic [7:0]  memRdData,
  input  wire logic        memReady
);
  function automatic pdc_byte_t ptrBase(input pdc_byte_t ptr, input logic odd);
    return {ptr[7:1], odd};
  endfunction

  pdc_rf_if rf ();
  pdc_regfile u_regfile (.clk(clk), .reset_n(reset_n), .rf(rf));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pdc_byte_t  cptr0_ff, aptr0_ff, cptr1_ff, aptr1_ff;
  logic       pend_ff, en_ff, eob_ff, swapEn_ff, tblSel_ff;
  pdc_prio_t  prio_ff;
  pdc_state_e state_ff, nxt_state;
  logic [3:0] stepCnt_ff;
  logic [2:0] tickCnt_ff;
  logic [15:0] adr_ff, cnt_ff;
  logic        dmaAck_ff, irqAck_ff, eobIrq_ff, perWrStb_ff;
  pdc_byte_t   perWrData_ff, memWrData_ff;
  logic [23:0] memAddr_ff;
  logic        awHeld_ff, wHeld_ff, arHeld_ff, rdWait_ff, bvalid_ff, rvalid_ff;
  logic [11:0] awAddr_ff, arAddr_ff;
  logic [31:0] wData_ff, rdata_ff;
  logic        wStrb0_ff;
  logic [1:0]  bresp_ff, rresp_ff;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire winW     = awAddr_ff[11:10] == `PDC_RF_WIN;
  wire winR     = arAddr_ff[11:10] == `PDC_RF_WIN;
  wire busyS    = state_ff == ST_BUSY;
  wire doWrite  = awHeld_ff & wHeld_ff & ~(winW & busyS);
  wire rfWrGo   = doWrite & winW & wStrb0_ff;
  wire rfRdGo   = arHeld_ff & winR & ~busyS & ~rfWrGo & ~rdWait_ff;
  wire doRegRd  = arHeld_ff & ~winR;
  wire wrByte   = doWrite & wStrb0_ff;
  wire wrCptr0  = wrByte & (awAddr_ff == `PDC_OFS_CPTR0);
  wire wrAptr0  = wrByte & (awAddr_ff == `PDC_OFS_APTR0);
  wire wrSrc    = wrByte & (awAddr_ff == `PDC_OFS_SRC);
  wire wrSwap   = wrByte & (awAddr_ff == `PDC_OFS_SWAP);
  wire wrCptr1  = wrByte & (awAddr_ff == `PDC_OFS_CPTR1);
  wire wrAptr1  = wrByte & (awAddr_ff == `PDC_OFS_APTR1);
  wire wHit     = winW | (awAddr_ff <= `PDC_OFS_STAT && awAddr_ff[1:0] == 2'h0);
  wire rHit     = arAddr_ff <= `PDC_OFS_STAT && arAddr_ff[1:0] == 2'h0;
  wire stWait   = state_ff == ST_WAIT;
  wire [7:0] srcVal  = {2'h0, pend_ff, en_ff, eob_ff, prio_ff};
  wire [7:0] statVal = {5'h00, tblSel_ff, stWait, busyS};
  wire [7:0] regRdVal =
      (arAddr_ff == `PDC_OFS_CPTR0) ? cptr0_ff :
      (arAddr_ff == `PDC_OFS_APTR0) ? aptr0_ff :
      (arAddr_ff == `PDC_OFS_SRC)   ? srcVal :
      (arAddr_ff == `PDC_OFS_SWAP)  ? {7'h00, swapEn_ff} :
      (arAddr_ff == `PDC_OFS_CPTR1) ? cptr1_ff :
      (arAddr_ff == `PDC_OFS_APTR1) ? aptr1_ff :
      (arAddr_ff == `PDC_OFS_STAT)  ? statVal : 8'h00;

  assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
  assign s_axi_wready  = ~wHeld_ff & ~bvalid_ff;
  assign s_axi_arready = ~arHeld_ff & ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_ff <= 1'h0;
      wHeld_ff  <= 1'h0;
      awAddr_ff <= 12'h000;
      wData_ff  <= 32'h0000_0000;
      wStrb0_ff <= 1'h0;
      bvalid_ff <= 1'h0;
      bresp_ff  <= `PDC_RESP_OK;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_ff <= 1'h1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'h0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_ff  <= 1'h1;
        wData_ff  <= s_axi_wdata;
        wStrb0_ff <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_ff <= 1'h0;
      end
      if (doWrite) begin
        bvalid_ff <= 1'h1;
        bresp_ff  <= wHit ? `PDC_RESP_OK : `PDC_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // Register-file reads wait while the engine owns the store
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arHeld_ff <= 1'h0;
      arAddr_ff <= 12'h000;
      rdWait_ff <= 1'h0;
      rvalid_ff <= 1'h0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `PDC_RESP_OK;
    end else begin
      rdWait_ff <= rfRdGo;
      if (s_axi_arvalid & s_axi_arready) begin
        arHeld_ff <= 1'h1;
        arAddr_ff <= s_axi_araddr;
      end else if (doRegRd | rdWait_ff) begin
        arHeld_ff <= 1'h0;
      end
      if (doRegRd | rdWait_ff) begin
        rvalid_ff <= 1'h1;
        rdata_ff  <= {24'h00_0000, rdWait_ff ? rf.rdata : regRdVal};
        rresp_ff  <= (rdWait_ff | rHit) ? `PDC_RESP_OK : `PDC_RESP_ERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  wire tick     = tickCnt_ff == `PDC_SAMPLE_CYC - 3'h1;
  wire dmaReq   = pend_ff & en_ff;
  // Lower code is the higher level, so "at or above" is <=
  wire dmaElig  = dmaReq & (prio_ff <= currentPriority) & ~topIsrActive;
  wire irqElig  = irqReq & (irqPrio < currentPriority);
  wire idleS    = state_ff == ST_IDLE;
  wire grantDma = tick & idleS & dmaElig & (~irqElig | prio_ff <= irqPrio);
  wire grantIrq = tick & idleS & irqElig & ~grantDma;

  assign dmaAck       = dmaAck_ff;
  assign irqAck       = irqAck_ff;
  assign cpuHold      = busyS;
  assign blockEndIrq  = eobIrq_ff;
  assign blockEndPrio = prio_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_ff <= 3'h0;
    end else begin
      tickCnt_ff <= tick ? 3'h0 : tickCnt_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  wire pdc_byte_t actCptr = tblSel_ff ? cptr1_ff : cptr0_ff;
  wire pdc_byte_t actAptr = tblSel_ff ? aptr1_ff : aptr0_ff;
  wire rfMode   = actCptr[`PDC_BIT_SPACE];
  wire pdc_byte_t cBase  = ptrBase(actCptr, 1'h0);
  wire pdc_byte_t cBaseP = ptrBase(actCptr, 1'h1);
  wire pdc_byte_t aBase  = ptrBase(actAptr, 1'h0);
  wire pdc_byte_t aBaseP = ptrBase(actAptr, 1'h1);
  wire [15:0] adrInc = adr_ff + 16'h0001;
  wire [15:0] cntDec = cnt_ff - 16'h0001;
  // Memory count of zero wraps, giving the full 65536 block
  wire lastTx   = rfMode ? cntDec[7:0] == 8'h00 : cntDec == 16'h0000;
  wire [4:0] cycLen = rfMode ? `PDC_RF_CYCLES : `PDC_MEM_CYCLES;
  wire endStep  = busyS & ({1'h0, stepCnt_ff} == cycLen - 5'h01);
  wire endBlock = endStep & lastTx;
  wire memStep  = busyS & ~rfMode & stepCnt_ff == 4'h6;
  wire stall    = memStep & ~memReady;
  wire capAdrLo = busyS & stepCnt_ff == (rfMode ? 4'h1 : 4'h4);
  wire capAdrHi = busyS & ~rfMode & stepCnt_ff == 4'h3;
  wire capCntLo = busyS & stepCnt_ff == 4'h2;
  wire capCntHi = busyS & ~rfMode & stepCnt_ff == 4'h1;
  wire capPerRf = busyS & rfMode & ~dirToStore & stepCnt_ff == 4'h3;
  wire capPerMem = memStep & memReady & ~dirToStore;
  wire pdc_byte_t segSel = actAptr[`PDC_BIT_SEG] ? transferSegReg : interruptSegReg;

  assign memReq       = memStep;
  assign memWe        = memStep & dirToStore;
  assign memAddr      = memAddr_ff;
  assign memWrData    = memWrData_ff;
  assign periphWrData = perWrData_ff;
  assign periphWrStb  = perWrStb_ff;
  assign periphRdStb  = busyS & dirToStore &
                        (rfMode ? stepCnt_ff == 4'h2 : memStep & memReady);

  pdc_byte_t eAddr, eWd;
  logic      eWe;
  // Descriptor fetch, datum move and write-back per step
  always_comb begin
    eAddr = 8'h00;
    eWe   = 1'h0;
    eWd   = 8'h00;
    case ({rfMode, stepCnt_ff})
      5'h10: eAddr = cBase;
      5'h11: eAddr = cBaseP;
      5'h12: begin
        eAddr = adr_ff[7:0];
        eWe   = dirToStore;
        eWd   = periphRdData;
      end
      5'h14: begin
        eAddr = cBase;
        eWe   = 1'h1;
        eWd   = adrInc[7:0];
      end
      5'h15: begin
        eAddr = cBaseP;
        eWe   = 1'h1;
        eWd   = cntDec[7:0];
      end
      5'h00: eAddr = cBase;
      5'h01: eAddr = cBaseP;
      5'h02: eAddr = aBase;
      5'h03: eAddr = aBaseP;
      5'h07: begin
        eAddr = aBase;
        eWe   = 1'h1;
        eWd   = adrInc[15:8];
      end
      5'h08: begin
        eAddr = aBaseP;
        eWe   = 1'h1;
        eWd   = adrInc[7:0];
      end
      5'h09: begin
        eAddr = cBase;
        eWe   = 1'h1;
        eWd   = cntDec[15:8];
      end
      5'h0A: begin
        eAddr = cBaseP;
        eWe   = 1'h1;
        eWd   = cntDec[7:0];
      end
      default: ;
    endcase
  end

  assign rf.addr  = busyS ? eAddr : (rfWrGo ? awAddr_ff[9:2] : arAddr_ff[9:2]);
  assign rf.we    = busyS ? eWe : rfWrGo;
  assign rf.wdata = busyS ? eWd : wData_ff[7:0];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (grantDma) nxt_state = ST_WAIT;
      ST_WAIT: if (instrDone) nxt_state = ST_BUSY;
      ST_BUSY: if (endStep) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= ST_IDLE;
      stepCnt_ff <= 4'h0;
    end else begin
      state_ff   <= nxt_state;
      stepCnt_ff <= (~busyS | endStep) ? 4'h0 : (stall ? stepCnt_ff : stepCnt_ff + 4'h1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adr_ff       <= 16'h0000;
      cnt_ff       <= 16'h0000;
      perWrData_ff <= 8'h00;
      perWrStb_ff  <= 1'h0;
      memWrData_ff <= 8'h00;
      memAddr_ff   <= 24'h00_0000;
    end else begin
      if (capAdrLo) adr_ff[7:0]  <= rf.rdata;
      if (capAdrHi) adr_ff[15:8] <= rf.rdata;
      if (capCntLo) cnt_ff[7:0]  <= rf.rdata;
      if (capCntHi) cnt_ff[15:8] <= rf.rdata;
      if (capPerRf) perWrData_ff <= rf.rdata;
      else if (capPerMem) perWrData_ff <= memRdData;
      perWrStb_ff  <= capPerRf | capPerMem;
      memWrData_ff <= periphRdData;
      memAddr_ff   <= {segSel, adr_ff};
    end
  end

  // ----------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------
  // Trigger beats both software clear and grant clear
  wire nxt_pend = trigEvent | (wrSrc ? wData_ff[`PDC_BIT_PEND] : (pend_ff & ~grantDma));
  wire nxt_en   = wrSrc ? wData_ff[`PDC_BIT_EN] : (en_ff & ~(endBlock & ~swapEn_ff));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cptr0_ff  <= `PDC_RST_BYTE;
      aptr0_ff  <= `PDC_RST_BYTE;
      cptr1_ff  <= `PDC_RST_BYTE;
      aptr1_ff  <= `PDC_RST_BYTE;
      pend_ff   <= 1'h0;
      en_ff     <= 1'h0;
      eob_ff    <= 1'h0;
      prio_ff   <= `PDC_RST_PRIO;
      swapEn_ff <= 1'h0;
      tblSel_ff <= 1'h0;
      dmaAck_ff <= 1'h0;
      irqAck_ff <= 1'h0;
      eobIrq_ff <= 1'h0;
    end else begin
      if (wrCptr0) cptr0_ff <= wData_ff[7:0];
      if (wrAptr0) aptr0_ff <= wData_ff[7:0];
      if (wrCptr1) cptr1_ff <= wData_ff[7:0];
      if (wrAptr1) aptr1_ff <= wData_ff[7:0];
      if (wrSwap) swapEn_ff <= wData_ff[`PDC_BIT_SWAP];
      if (wrSrc) begin
        eob_ff  <= wData_ff[`PDC_BIT_EOB];
        prio_ff <= wData_ff[2:0];
      end
      pend_ff   <= nxt_pend;
      en_ff     <= nxt_en;
      if (endBlock & swapEn_ff) tblSel_ff <= ~tblSel_ff;
      dmaAck_ff <= grantDma;
      irqAck_ff <= grantIrq;
      eobIrq_ff <= endBlock & eob_ff;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence sRfRun;
    busyS [*8] ##1 !busyS;
  endsequence
  sequence sGrantWait;
    stWait && instrDone ##1 busyS && stepCnt_ff == 4'h0;
  endsequence

  chk_tick_period: assert property (tick |=> !tick [*4] ##1 tick)
    else $error("request sampling not every five cycles");
  chk_rf_length: assert property ($rose(busyS) && rfMode |-> sRfRun)
    else $error("register-file transfer not eight cycles");
  chk_mem_length: assert property ($fell(busyS) && !$past(rfMode) |-> $past(stepCnt_ff) == 4'hF)
    else $error("memory transfer shorter than sixteen cycles");
  chk_grant_wait: assert property (dmaAck |-> stWait)
    else $error("grant did not enter the wait state");
  chk_wait_hold: assert property (stWait && !instrDone |=> stWait)
    else $error("transfer began before instruction end");
  chk_wait_end: assert property (stWait && instrDone |-> sGrantWait)
    else $error("transfer did not start after instruction end");
  chk_dma_gate: assert property (dmaAck |-> $past(pend_ff && en_ff && prio_ff <= currentPriority && !topIsrActive))
    else $error("DMA grant without enable or priority");
  chk_irq_strict: assert property (irqAck |-> $past(irqPrio < currentPriority && !(dmaElig && prio_ff <= irqPrio)))
    else $error("interrupt grant not strictly above level");
  chk_busy_noirq: assert property (busyS |-> !irqAck && !dmaAck)
    else $error("grant during transfer");
  chk_eob_clear: assert property (endBlock && !swapEn_ff && !wrSrc |=> !en_ff && (eobIrq_ff == $past(eob_ff)))
    else $error("block end did not clear enable");
  chk_swap_keep: assert property (endBlock && swapEn_ff && !wrSrc |=> en_ff && tblSel_ff != $past(tblSel_ff))
    else $error("swap did not toggle table");
  chk_pend_set: assert property (trigEvent |=> pend_ff)
    else $error("trigger lost");
endmodule

/* pdc_cfg.svh */
// Register map, field positions, reset values and cycle counts of the DMA channel
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
`define PDC_OFS_CPTR0    12'h000
`define PDC_OFS_APTR0    12'h004
`define PDC_OFS_SRC      12'h008
`define PDC_OFS_SWAP     12'h00C
`define PDC_OFS_CPTR1    12'h010
`define PDC_OFS_APTR1    12'h014
`define PDC_OFS_STAT     12'h018
`define PDC_RF_WIN       2'h1
`define PDC_BIT_SPACE    0
`define PDC_BIT_SEG      0
`define PDC_BIT_PEND     5
`define PDC_BIT_EN       4
`define PDC_BIT_EOB      3
`define PDC_BIT_SWAP     0
`define PDC_RST_BYTE     8'h00
`define PDC_RST_PRIO     3'h0
`define PDC_SAMPLE_CYC   3'h5
`define PDC_RF_CYCLES    5'h08
`define PDC_MEM_CYCLES   5'h10
`define PDC_RESP_OK      2'h0
`define PDC_RESP_ERR     2'h2
`endif

/* pdc_pkg.sv */
// Types shared by the DMA channel files
package pdc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_BUSY = 3'h4
  } pdc_state_e;
  typedef logic [7:0] pdc_byte_t;
  typedef logic [2:0] pdc_prio_t;
endpackage

/* pdc_rf_if.sv */
// Port of the channel's descriptor register file
`timescale 1ns/1ps
interface pdc_rf_if;
  logic [7:0] addr;
  logic       we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport owner (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface

/* pdc_regfile.sv */
// Descriptor register file: 256 bytes, registered read data
`timescale 1ns/1ps
module pdc_regfile (
  input wire logic clk,
  input wire logic reset_n,
  pdc_rf_if.store  rf
);
  logic [7:0] mem [256];
  logic [7:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (rf.we) begin
      mem[rf.addr] <= rf.wdata;
    end
  end

  // Read of a location being written returns the old byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= mem[rf.addr];
    end
  end

  assign rf.rdata = rdata_ff;
endmodule

/* pdc_far_model.sv */
// Far-side model: peripheral data register, instruction timing, memory port
`timescale 1ns/1ps
module pdc_far_model (
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  memReq,
  output logic       instrDone,
  output logic       memReady,
  output logic [7:0] periphRdData,
  output logic [7:0] memRdData
);
  logic [1:0] phase_ff;
  logic       waited_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff  <= 2'h0;
      waited_ff <= 1'b0;
    end else begin
      phase_ff  <= phase_ff + 2'h1;
      waited_ff <= memReq & ~waited_ff;
    end
  end
  // Instruction ends every fourth cycle, so transfers must wait for it
  assign instrDone    = (phase_ff == 2'h3);
  // One wait state on every memory access
  assign memReady     = memReq & waited_ff;
  assign periphRdData = 8'h5A;
  // Not a real answer outside an access: pattern moves each cycle
  assign memRdData    = memReady ? 8'hC3 : {4{phase_ff}};
endmodule

/* testbench.sv */
// Self-checking bench of the peripheral DMA channel
`timescale 1ns/1ps
module testbench;
  import pdc_pkg::*;
  logic        clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, trigEvent, dirToStore, periphRdStb, periphWrStb, irqReq;
  logic        topIsrActive, instrDone, dmaAck, irqAck, cpuHold, blockEndIrq;
  logic        memReq, memWe, memReady, irqSeen;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, gotAddr, gotData;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  periphRdData, periphWrData, memWrData, memRdData;
  logic [7:0]  interruptSegReg, transferSegReg;
  logic [23:0] memAddr;
  pdc_prio_t   currentPriority, irqPrio, blockEndPrio;
  int          mismatches, cmp_count, cycles;

  pdc_dma_channel dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigEvent, .dirToStore, .periphRdData,
    .periphRdStb, .periphWrData, .periphWrStb, .currentPriority, .irqReq, .irqPrio,
    .topIsrActive, .instrDone, .dmaAck, .irqAck, .cpuHold, .blockEndIrq, .blockEndPrio,
    .interruptSegReg, .transferSegReg, .memReq, .memWe, .memAddr, .memWrData,
    .memRdData, .memReady);
  pdc_far_model far (.clk, .reset_n, .memReq, .instrDone, .memReady, .periphRdData,
    .memRdData);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) if (irqAck === 1'b1) irqSeen = 1'b1;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, ta, tw;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = !aw && s_axi_awready === 1'b1;
      tw = !w && s_axi_wready === 1'b1;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw = aw | ta;
      w = w | tw;
    end while (!(aw && w));
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, 0);
    // Ready stays up so back-to-back writes never touch it twice in a step
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic trig;
    trigEvent <= 1'b1;
    @(posedge clk);
    trigEvent <= 1'b0;
  endtask
  task automatic noack;
    repeat (20) begin
      @(negedge clk);
      chk(dmaAck, 0);
    end
    @(posedge clk);
  endtask
  // Waits for the grant, then measures the busy window
  task automatic xfer(input int base, input logic expEob);
    int hold, waits, n, stb;
    logic eob, lastDone;
    hold = 0;
    waits = 0;
    n = 0;
    stb = 0;
    eob = 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (dmaAck !== 1'b1 && n < 40);
    chk(irqSeen, 0);
    repeat (40) begin
      lastDone = instrDone;
      @(negedge clk);
      if (cpuHold === 1'b1 && hold == 0) chk(lastDone, 1);
      if (cpuHold === 1'b1) hold++;
      if (memReq === 1'b1 && memReady !== 1'b1) waits++;
      if (memReq === 1'b1) gotAddr = {8'h00, memAddr};
      if (memReq === 1'b1) gotData = {23'h00_0000, memWe, memWrData};
      if (periphWrStb === 1'b1) gotData = {24'h00_0000, periphWrData};
      if (periphRdStb === 1'b1 || periphWrStb === 1'b1) stb++;
      if (blockEndIrq === 1'b1) eob = 1'b1;
    end
    chk(32'(hold), 32'(base + waits));
    chk(eob, expEob);
    chk(32'(stb), 1);
    @(posedge clk);
  endtask

  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {trigEvent, irqReq, topIsrActive, irqSeen, cycles} = 0;
    s_axi_wstrb = 4'h1;
    dirToStore = 1'b1;
    {currentPriority, irqPrio} = 6'h00;
    interruptSegReg = 8'h44;
    transferSegReg = 8'h77;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(12'h008, 0, 2'h0);
    rd(12'h020, 0, 2'h2);
    // Register-file table: address 0x40, two transfers
    wr(12'h440, 8'h40);
    wr(12'h444, 8'h02);
    wr(12'h000, 8'h11);
    wr(12'h008, 8'h1D);
    currentPriority <= 3'h5;
    trig();
    xfer(8, 1'b0);
    rd(12'h440, 8'h41, 2'h0);
    rd(12'h444, 8'h01, 2'h0);
    rd(12'h500, 8'h5A, 2'h0);
    trig();
    xfer(8, 1'b1);
    rd(12'h008, 8'h0D, 2'h0);
    wr(12'h444, 8'h01);
    // Service flag up before the request lands, or a tick could grant it
    topIsrActive <= 1'b1;
    wr(12'h008, 8'h3D);
    noack();
    topIsrActive <= 1'b0;
    currentPriority <= 3'h4;
    noack();
    currentPriority <= 3'h6;
    irqPrio <= 3'h5;
    irqReq <= 1'b1;
    xfer(8, 1'b1);
    repeat (30) @(posedge clk);
    chk(irqSeen, 1);
    irqReq <= 1'b0;
    // Let a grant sampled with the old request drain before clearing
    repeat (2) @(posedge clk);
    irqSeen = 1'b0;
    // Memory table: one transfer, segment from the transfer register
    wr(12'h480, 8'h00);
    wr(12'h484, 8'h01);
    wr(12'h4C0, 8'h12);
    wr(12'h4C4, 8'h34);
    wr(12'h000, 8'h20);
    wr(12'h004, 8'h31);
    currentPriority <= 3'h1;
    wr(12'h008, 8'h31);
    xfer(16, 1'b0);
    chk(gotAddr, 32'h0077_1234);
    chk(gotData, 32'h0000_015A);
    rd(12'h4C4, 8'h35, 2'h0);
    rd(12'h484, 8'h00, 2'h0);
    rd(12'h008, 8'h01, 2'h0);
    // Swap between two register-file tables, peripheral fed from storage
    dirToStore <= 1'b0;
    wr(12'h444, 8'h01);
    wr(12'h50C, 8'hA5);
    wr(12'h448, 8'h60);
    wr(12'h44C, 8'h01);
    wr(12'h580, 8'h3C);
    wr(12'h000, 8'h11);
    wr(12'h010, 8'h13);
    wr(12'h00C, 8'h01);
    wr(12'h008, 8'h39);
    xfer(8, 1'b1);
    chk(gotData, 32'h0000_00A5);
    rd(12'h018, 8'h04, 2'h0);
    trig();
    xfer(8, 1'b1);
    chk(gotData, 32'h0000_003C);
    rd(12'h008, 8'h19, 2'h0);
    rd(12'h018, 8'h00, 2'h0);
    chk(blockEndPrio, 32'h0000_0001);
    stop_test();
  end
endmodule
